// file: rtl/pad_pkg.sv
// Package: register map, reset values and timing constants of the lamp dimmer
package pad_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam logic [15:0] ADDR_DET_TYPE = 16'hFEA0;
    localparam logic [15:0] ADDR_SW_STATE = 16'hFEA1;
    localparam logic [15:0] ADDR_LAMP_EN = 16'hFEA2;
    localparam logic [15:0] ADDR_REF3 = 16'hFEA3;
    localparam logic [15:0] ADDR_REF2 = 16'hFEA4;
    localparam logic [15:0] ADDR_REF1 = 16'hFEA5;
    localparam logic [15:0] ADDR_REF0 = 16'hFEA6;
    localparam logic [15:0] ADDR_POLARITY = 16'hFEA7;
    localparam logic [7:0] RST_DET_TYPE = 8'h00;
    localparam logic [7:0] RST_SW_STATE = 8'h00;
    localparam logic [7:0] RST_LAMP_EN = 8'h00;
    localparam logic [7:0] RST_REF = 8'h00;
    localparam logic [7:0] RST_POLARITY = 8'hFF;
    localparam int unsigned DET_TYPE_BIT = 0;
    localparam int unsigned POL_FIRE_LSB = 0;
    localparam int unsigned POL_SW_LSB = 4;
    localparam logic [7:0] REF_CONTINUOUS_BELOW = 8'd15;
    localparam logic [7:0] REF_NEVER_ABOVE = 8'd90;
    localparam int unsigned STEP_US = 100;
    localparam int unsigned STEP_CYCLES = CLK_HZ / 1_000_000 * STEP_US;
    localparam int unsigned PULSE_US = 200;
    localparam int unsigned PULSE_CYCLES = CLK_HZ / 1_000_000 * PULSE_US;
    localparam int unsigned SW_PULSE_MS = 2;
    localparam int unsigned SW_HOLD_CYCLES = CLK_HZ / 1000 * SW_PULSE_MS * 6;
endpackage : pad_pkg

// file: rtl/pad_channel.sv
// One triac firing channel: delay counter and pulse timer
`timescale 1ns/10ps
`default_nettype none
module pad_channel (
    input wire logic clk_sys_i, // System clock
    input wire logic arst_n_i, // Async reset, active low
    input wire logic step_i, // 100 us tick
    input wire logic zc_i, // Zero crossing pulse
    input wire logic enable_i, // Lamp enable
    input wire logic [7:0] ref_i, // Phase reference
    input wire logic pol_i, // Firing polarity, 1 = active low
    output logic triac_o // Triac pin
);
    import pad_pkg::*;
    logic [7:0] step_cnt_reg;
    logic [12:0] pulse_cnt_reg;
    logic armed_reg;
    logic fire_reg;
    logic continuous;
    assign continuous = ref_i < REF_CONTINUOUS_BELOW;

    // Step counter restarts at each crossing
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            step_cnt_reg <= 8'h00;
        end else if (zc_i) begin
            step_cnt_reg <= 8'h00;
        end else if (step_i && step_cnt_reg != 8'hFF) begin
            step_cnt_reg <= step_cnt_reg + 8'h01;
        end
    end

    // One shot per half cycle; re-armed only by a crossing
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            armed_reg <= 1'b0;
            pulse_cnt_reg <= 13'h0000;
            fire_reg <= 1'b0;
        end else if (zc_i) begin
            armed_reg <= 1'b1;
            pulse_cnt_reg <= 13'h0000;
            fire_reg <= 1'b0;
        end else if (armed_reg && step_cnt_reg == ref_i) begin
            armed_reg <= 1'b0;
            if (ref_i <= REF_NEVER_ABOVE) begin
                fire_reg <= 1'b1;
                pulse_cnt_reg <= 13'(PULSE_CYCLES - 1);
            end
        end else if (fire_reg) begin
            if (pulse_cnt_reg == 13'h0000) begin
                fire_reg <= 1'b0;
            end else begin
                pulse_cnt_reg <= pulse_cnt_reg - 13'h0001;
            end
        end
    end

    // Output level with polarity; continuous firing overrides pulse
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            triac_o <= 1'b1;
        end else begin
            triac_o <= pol_i ^ (enable_i && (continuous || fire_reg));
        end
    end
endmodule : pad_channel
`default_nettype wire

// file: rtl/pad_dimmer.sv
// Phase-angle lamp dimmer with byte register file on external data bus
`timescale 1ns/10ps
`default_nettype none
module pad_dimmer (
    input wire logic clk_sys_i, // System clock, 20 MHz
    input wire logic arst_n_i, // Async reset, active low
    input wire logic [15:0] xaddr_i, // External data address
    input wire logic [7:0] xwdata_i, // Write data
    input wire logic xwr_i, // Write strobe, one cycle
    input wire logic xrd_i, // Read strobe, one cycle
    output logic [7:0] xrdata_o, // Read data, registered
    output logic xsel_o, // Address hit on last read
    input wire logic zero_cross_input_i, // Zero-cross detector pin
    input wire logic [3:0] switch_input_i, // Switch pins, high while on
    output logic [3:0] triac_o, // Triac firing pins
    output logic detector_type_bit_o // Detector type for analogue front end
);
    import pad_pkg::*;

    logic [7:0] det_type_reg;
    logic [7:0] lamp_en_reg;
    logic [7:0] ref_reg [4];
    logic [7:0] pol_reg;
    logic [7:0] sw_state_reg;
    logic [1:0] zc_sync_reg;
    logic [3:0] sw_sync0_reg;
    logic [3:0] sw_sync1_reg;
    logic zc_prev_reg;
    logic zc_pulse;
    logic [10:0] step_cnt_reg;
    logic step_tick;
    logic [3:0] sw_on;
    logic [3:0] triac_w;

    // Two flops before any logic looks at the pins
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            zc_sync_reg <= 2'h0;
            sw_sync0_reg <= 4'h0;
            sw_sync1_reg <= 4'h0;
        end else begin
            zc_sync_reg <= {zc_sync_reg[0], zero_cross_input_i};
            sw_sync0_reg <= switch_input_i;
            sw_sync1_reg <= sw_sync0_reg;
        end
    end

    // Either edge of the detector marks a crossing
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            zc_prev_reg <= 1'b0;
        end else begin
            zc_prev_reg <= zc_sync_reg[1];
        end
    end
    assign zc_pulse = zc_sync_reg[1] ^ zc_prev_reg;

    // 100 us time base, phase-locked to the crossing
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            step_cnt_reg <= 11'h000;
        end else if (zc_pulse || step_cnt_reg == 11'(STEP_CYCLES - 1)) begin
            step_cnt_reg <= 11'h000;
        end else begin
            step_cnt_reg <= step_cnt_reg + 11'h001;
        end
    end
    assign step_tick = step_cnt_reg == 11'(STEP_CYCLES - 1);

    // Switch stretcher: a short opto pulse holds "on" across the half-cycle gaps
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sw
            logic [17:0] hold_reg;
            always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    hold_reg <= 18'h00000;
                end else if (sw_sync1_reg[gi]) begin
                    hold_reg <= 18'(SW_HOLD_CYCLES);
                end else if (hold_reg != 18'h00000) begin
                    hold_reg <= hold_reg - 18'h00001;
                end
            end
            assign sw_on[gi] = sw_sync1_reg[gi] || hold_reg != 18'h00000;
        end
    endgenerate

    // Reported state with per-channel polarity
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sw_state_reg <= RST_SW_STATE;
        end else begin
            sw_state_reg <= {4'h0, ~(sw_on ^ pol_reg[POL_SW_LSB +: 4])};
        end
    end

    // Register writes; switch state has no write path
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            det_type_reg <= RST_DET_TYPE;
            lamp_en_reg <= RST_LAMP_EN;
            ref_reg[0] <= RST_REF;
            ref_reg[1] <= RST_REF;
            ref_reg[2] <= RST_REF;
            ref_reg[3] <= RST_REF;
            pol_reg <= RST_POLARITY;
        end else if (xwr_i) begin
            if (xaddr_i == ADDR_DET_TYPE) begin
                det_type_reg <= {7'h00, xwdata_i[DET_TYPE_BIT]};
            end else if (xaddr_i == ADDR_LAMP_EN) begin
                lamp_en_reg <= xwdata_i;
            end else if (xaddr_i == ADDR_REF3) begin
                ref_reg[3] <= xwdata_i;
            end else if (xaddr_i == ADDR_REF2) begin
                ref_reg[2] <= xwdata_i;
            end else if (xaddr_i == ADDR_REF1) begin
                ref_reg[1] <= xwdata_i;
            end else if (xaddr_i == ADDR_REF0) begin
                ref_reg[0] <= xwdata_i;
            end else if (xaddr_i == ADDR_POLARITY) begin
                pol_reg <= xwdata_i;
            end
        end
    end

    // Registered read; unmapped reads return 00 with select low
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            xrdata_o <= 8'h00;
            xsel_o <= 1'b0;
        end else if (xrd_i) begin
            xsel_o <= 1'b1;
            if (xaddr_i == ADDR_DET_TYPE) begin
                xrdata_o <= det_type_reg;
            end else if (xaddr_i == ADDR_SW_STATE) begin
                xrdata_o <= sw_state_reg;
            end else if (xaddr_i == ADDR_LAMP_EN) begin
                xrdata_o <= lamp_en_reg;
            end else if (xaddr_i == ADDR_REF3) begin
                xrdata_o <= ref_reg[3];
            end else if (xaddr_i == ADDR_REF2) begin
                xrdata_o <= ref_reg[2];
            end else if (xaddr_i == ADDR_REF1) begin
                xrdata_o <= ref_reg[1];
            end else if (xaddr_i == ADDR_REF0) begin
                xrdata_o <= ref_reg[0];
            end else if (xaddr_i == ADDR_POLARITY) begin
                xrdata_o <= pol_reg;
            end else begin
                xrdata_o <= 8'h00;
                xsel_o <= 1'b0;
            end
        end else begin
            xsel_o <= 1'b0;
        end
    end

    // One channel per triac; reference n drives output n
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ch
            pad_channel u_ch (
                .clk_sys_i(clk_sys_i),
                .arst_n_i(arst_n_i),
                .step_i(step_tick),
                .zc_i(zc_pulse),
                .enable_i(lamp_en_reg[gi]),
                .ref_i(ref_reg[gi]),
                .pol_i(pol_reg[POL_FIRE_LSB + gi]),
                .triac_o(triac_w[gi])
            );
        end
    endgenerate
    assign triac_o = triac_w;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            detector_type_bit_o <= 1'b0;
        end else begin
            detector_type_bit_o <= det_type_reg[DET_TYPE_BIT];
        end
    end
endmodule : pad_dimmer
`default_nettype wire

// file: tb/pad_dimmer_checker.sv
// Checker: bus and triac assertions for the lamp dimmer
`timescale 1ns/10ps
`default_nettype none
module pad_dimmer_checker import pad_pkg::*; (
    input wire logic clk_sys_i, // Clock
    input wire logic arst_n_i, // Reset
    input wire logic [15:0] xaddr_i, // Address
    input wire logic [7:0] xwdata_i, // Write data
    input wire logic xwr_i, // Write strobe
    input wire logic xrd_i, // Read strobe
    input wire logic [7:0] xrdata_o, // Read data
    input wire logic xsel_o, // Hit flag
    input wire logic [3:0] triac_o, // Triac pins
    input wire logic detector_type_bit_o // Detector type
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    logic [7:0] pol_q, pol_d, en_q, en_d;
    logic [7:0] ref_q [4];
    logic [7:0] ref_d [4];
    logic [15:0] cnt;
    logic [3:0] act;
    logic hit;
    assign hit = xaddr_i[15:3] == 13'h1FD4;
    // Output flop lags the registers by one edge
    assign act = triac_o ^ pol_d[3:0];
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pol_q <= 8'hFF;
            pol_d <= 8'hFF;
            en_q <= 8'h00;
            en_d <= 8'h00;
            cnt <= 16'h0000;
            for (int i = 0; i < 4; i++) begin
                ref_q[i] <= 8'h00;
                ref_d[i] <= 8'h00;
            end
        end else begin
            if (xwr_i && xaddr_i == ADDR_POLARITY) pol_q <= xwdata_i;
            if (xwr_i && xaddr_i == ADDR_LAMP_EN) en_q <= xwdata_i;
            if (xwr_i && hit && xaddr_i[2:0] inside {[3:6]}) ref_q[3'd6 - xaddr_i[2:0]] <= xwdata_i;
            pol_d <= pol_q;
            en_d <= en_q;
            ref_d <= ref_q;
            cnt <= act[0] ? cnt + 16'h0001 : 16'h0000;
        end
    end
    sel_map_a: assert property (xrd_i && hit |=> xsel_o) else $error("no select");
    unmap_rd_a: assert property (xrd_i && !hit |=> !xsel_o && xrdata_o == 8'h00)
        else $error("unmapped read");
    sel_cause_a: assert property (xsel_o |-> $past(xrd_i && hit)) else $error("stray select");
    rd_hold_a: assert property (!xrd_i |=> $stable(xrdata_o)) else $error("data moved");
    ro_upper_a: assert property (xrd_i && xaddr_i == ADDR_SW_STATE |=> xrdata_o[7:4] == 4'h0)
        else $error("upper bits set");
    det_copy_a: assert property (xwr_i && xaddr_i == ADDR_DET_TYPE |-> ##2
        detector_type_bit_o == $past(xwdata_i[0], 2)) else $error("detector bit");
    never_fire_a: assert property (ref_d[1] > REF_NEVER_ABOVE && $stable(pol_d) |-> !act[1])
        else $error("fired above limit");
    cont_fire_a: assert property (en_d[2] && $past(en_d[2]) && ref_d[2] < REF_CONTINUOUS_BELOW
        && $stable(pol_d) |-> act[2]) else $error("not continuous");
    off_fire_a: assert property (!en_d[3] && !$past(en_d[3]) && $stable(pol_d) |-> !act[3])
        else $error("disabled lamp fired");
    pulse_len_a: assert property ($fell(act[0]) && ref_d[0] >= REF_CONTINUOUS_BELOW |->
        cnt >= PULSE_CYCLES && cnt <= PULSE_CYCLES + 1) else $error("pulse width");
    cover property (xsel_o);
    cover property ($rose(act[0]));
    cover property (act[2] && en_d[2]);
endmodule : pad_dimmer_checker
`default_nettype wire

// file: tb/pad_mains_model.sv
// Partner model: mains zero-cross detector and optocoupled switches
`timescale 1ns/10ps
`default_nettype none
module pad_mains_model (
    input wire logic clk_sys_i, // System clock
    input wire logic cross_req_i, // Request one crossing
    input wire logic [3:0] sw_on_i, // Switches closed
    output logic zero_cross_input_o, // Detector pin
    output logic [3:0] switch_input_o // Opto outputs, high while on
);
    // Detector flips per half-cycle; the delay keeps it off the clock edge
    initial zero_cross_input_o = 1'b0;
    always @(posedge clk_sys_i) begin
        if (cross_req_i) begin
            #13 zero_cross_input_o = ~zero_cross_input_o;
        end
    end
    assign switch_input_o = sw_on_i;
endmodule : pad_mains_model
`default_nettype wire

// file: tb/pad_dimmer_tb.sv
// Testbench: register map and triac firing of the lamp dimmer
`timescale 1ns/10ps
`default_nettype none
module pad_dimmer_tb;
    import pad_pkg::*;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [15:0] xaddr_i = 16'h0000;
    logic [7:0] xwdata_i = 8'h00;
    logic xwr_i = 1'b0;
    logic xrd_i = 1'b0;
    logic cross_req = 1'b0;
    logic [3:0] sw_on = 4'h0;
    logic [7:0] xrdata_o;
    logic xsel_o;
    logic zc;
    logic det_o;
    logic [3:0] sw_pin;
    logic [3:0] triac_o;
    logic [7:0] mem [8];
    integer seed = 32'hFE61C407;
    int error_cnt = 0;
    int checks_done = 0;
    int c;
    always #25 clk_sys_i = ~clk_sys_i;
    pad_dimmer i_dut (.clk_sys_i, .arst_n_i, .xaddr_i, .xwdata_i, .xwr_i, .xrd_i, .xrdata_o,
        .xsel_o, .zero_cross_input_i(zc), .switch_input_i(sw_pin), .triac_o,
        .detector_type_bit_o(det_o));
    pad_mains_model i_mains (.clk_sys_i, .cross_req_i(cross_req), .sw_on_i(sw_on),
        .zero_cross_input_o(zc), .switch_input_o(sw_pin));
    task automatic end_sim;
        $display("Checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        xaddr_i = a;
        xwdata_i = d;
        xwr_i = 1'b1;
        @(negedge clk_sys_i);
        xwr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk_sys_i);
        xaddr_i = a;
        xrd_i = 1'b1;
        @(negedge clk_sys_i);
        xrd_i = 1'b0;
        chk(xrdata_o, e, "read");
        chk(xsel_o, a[15:3] == 13'h1FD4, "select");
    endtask : rd
    // Waits on triac 0, counting cycles; a hang ends the run
    task automatic wait_lvl(input logic v);
        c = 0;
        while (triac_o[0] !== v) begin
            @(negedge clk_sys_i);
            c++;
            if (c > 50000) begin
                error_cnt++;
                $display("ERROR %0t triac wait timed out", $time);
                end_sim();
            end
        end
    endtask : wait_lvl
    function automatic logic [7:0] rv(int n);
        if (n == 0) return mem[0] & 8'h01;
        if (n == 1) return {4'h0, ~(sw_on ^ mem[7][7:4])};
        return mem[n];
    endfunction : rv
    initial begin
        repeat (12) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        for (int n = 0; n < 8; n++) rd(ADDR_DET_TYPE + 16'(n), n == 7 ? RST_POLARITY : 8'h00);
        rd(16'hFEA8, 8'h00);
        rd(16'hFE9F, 8'h00);
        sw_on = 4'($random(seed));
        mem[7] = 8'hFF;
        for (int n = 0; n < 8; n++) begin
            mem[n] = (n == 1) ? mem[1] : 8'($random(seed));
            wr(ADDR_DET_TYPE + 16'(n), 8'($random(seed)) | mem[n]);
            mem[n] = (n == 1) ? mem[1] : mem[n] | xwdata_i;
            rd(ADDR_DET_TYPE + 16'(n), rv(n));
        end
        rd(ADDR_SW_STATE, rv(1));
        chk(det_o, mem[0][0], "detector bit");
        wr(ADDR_LAMP_EN, 8'h00);
        wr(ADDR_REF0, 8'd16);
        wr(ADDR_REF1, 8'd95);
        wr(ADDR_REF2, 8'd5);
        wr(ADDR_REF3, 8'd16);
        wr(ADDR_POLARITY, 8'hF4);
        wr(ADDR_LAMP_EN, 8'hF7);
        repeat (4) @(negedge clk_sys_i);
        chk(triac_o, 4'b0000, "idle");
        @(negedge clk_sys_i);
        cross_req = 1'b1;
        @(negedge clk_sys_i);
        cross_req = 1'b0;
        wait_lvl(1'b1);
        chk(c >= 16 * STEP_CYCLES && c <= 16 * STEP_CYCLES + 12, 1, "delay");
        chk(triac_o[3:1], 3'b000, "others");
        wait_lvl(1'b0);
        chk(c >= PULSE_CYCLES - 2 && c <= PULSE_CYCLES + 3, 1, "pulse");
        repeat (2000) @(negedge clk_sys_i);
        chk(triac_o[0], 1'b0, "refire");
        wr(ADDR_POLARITY, 8'hF0);
        repeat (3) @(negedge clk_sys_i);
        chk(triac_o, 4'b0100, "polarity");
        end_sim();
    end
endmodule : pad_dimmer_tb
bind pad_dimmer pad_dimmer_checker i_chk (.clk_sys_i, .arst_n_i, .xaddr_i, .xwdata_i, .xwr_i,
    .xrd_i, .xrdata_o, .xsel_o, .triac_o, .detector_type_bit_o);
`default_nettype wire
